/* File: design/pci_master_cfg_pkg.sv */
// Shared constants for the master policy, substitution and hook register block
package pci_master_cfg_pkg;
  localparam logic [11:0] OFF_ID_PROG = 12'h394;
  localparam logic [11:0] OFF_CLREV_PROG = 12'h39C;
  localparam logic [11:0] OFF_SUBID_PROG = 12'h3A0;
  localparam logic [11:0] OFF_LATGNT_PROG = 12'h3A4;
  localparam logic [11:0] OFF_CFG_DONE = 12'h3AC;
  localparam logic [11:0] OFF_MST_POLICY = 12'h390;
  localparam logic [11:0] OFF_PROXY_CMD = 12'h398;
  localparam logic [11:0] OFF_SUBST_BASE = 12'h300;
  localparam logic [11:0] SUBST_SPAN = 12'h080;
  localparam int POL_CFG_FLUSH = 10;
  localparam int POL_IO_FLUSH = 9;
  localparam int POL_MEM_FLUSH = 8;
  localparam int POL_RD_MULT = 2;
  localparam int POL_RD_LINE = 1;
  localparam int POL_WR_INV = 0;
  localparam logic [31:0] POL_MASK = 32'h0000_0707;
  localparam logic [31:0] POL_RESET = 32'h0000_0007;
  localparam int SUBST_COUNT = 32;
  localparam int SUBST_MSB = 31;
  localparam int SUBST_LSB = 23;
  localparam int SLICE_MSB = 27;
  localparam int SLICE_LSB = 23;
  localparam int PROXY_READY_BIT = 31;
  localparam int PROXY_TYPE_BIT = 2;
  localparam logic [31:0] PROXY_WR_MASK = 32'h0000_00F5;
  // Identity default is arbitrary, not a real maker code
  localparam logic [31:0] ID_PROG_RESET = 32'h0001_0001;
  localparam logic [31:0] CLREV_PROG_RESET = 32'h1180_0001;
  localparam logic [31:0] SUBID_PROG_RESET = 32'h0000_0000;
  localparam logic [31:0] LATGNT_MASK = 32'h0000_FFFF;
  localparam logic [31:0] LATGNT_RESET = 32'h0000_0000;
  localparam int PROXY_BUSY_CYCLES = 4;
  localparam logic [3:0] PCI_CMD_MEM_READ = 4'h6;
  localparam logic [3:0] PCI_CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] PCI_CMD_READ_MULT = 4'hC;
  localparam logic [3:0] PCI_CMD_READ_LINE = 4'hE;
  localparam logic [3:0] PCI_CMD_WRITE_INV = 4'hF;
  localparam logic [3:0] BURST_LINE_MIN = 4'h8;
  localparam logic [3:0] BURST_MULT_MIN = 4'hC;
endpackage

/* File: design/subst_mem_if.sv */
// Port bundle between the register block and the substitution memory
`timescale 1ns/1ps
interface subst_mem_if;
  logic wr_en;
  logic [4:0] wr_idx;
  logic [8:0] wr_data;
  logic [4:0] rd_idx;
  logic [8:0] rd_data;
  modport owner (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

/* File: design/subst_mem.sv */
// Thirty-two entry store of upper address replacement fields
`timescale 1ns/1ps
module subst_mem (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  subst_mem_if.store mem
);
  logic [8:0] entry_reg [0:31];
  logic [8:0] rd_data_reg;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 32; i++) begin
        entry_reg[i] <= 9'h000;
      end
    end else if (mem.wr_en) begin
      entry_reg[mem.wr_idx] <= mem.wr_data;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_reg <= 9'h000;
    end else begin
      rd_data_reg <= entry_reg[mem.rd_idx];
    end
  end

  assign mem.rd_data = rd_data_reg;
endmodule // subst_mem

/* File: design/pci_master_cfg_and_hook_regs.sv */
// Master command policy, address substitution and configuration hook registers
`timescale 1ns/1ps
module pci_master_cfg_and_hook_regs (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic bus_mastering_allowed_i,
  input wire logic pci_reset_i,
  input wire logic mem_req_valid_i,
  input wire logic mem_req_write_i,
  input wire logic [3:0] mem_req_burst_i,
  input wire logic [31:0] mem_req_addr_i,
  output logic mem_req_accept_o,
  output logic mem_req_flushed_o,
  output logic mem_cmd_valid_o,
  output logic [3:0] mem_cmd_o,
  output logic [31:0] mem_cmd_addr_o,
  input wire logic proxy_done_i,
  output logic proxy_start_o,
  output logic proxy_io_o,
  output logic [31:0] identity_mirror_o,
  output logic [31:0] class_rev_mirror_o,
  output logic [31:0] subsystem_mirror_o,
  output logic [15:0] latency_grant_mirror_o,
  output logic ext_access_allowed_o
);
  typedef enum logic [2:0] {
    PX_IDLE = 3'b001,
    PX_ISSUE = 3'b010,
    PX_WAIT = 3'b100
  } proxy_state_e;

  typedef enum logic [2:0] {
    MP_IDLE = 3'b001,
    MP_LOOKUP = 3'b010,
    MP_EMIT = 3'b100
  } mem_state_e;

  logic [31:0] policy_reg;
  logic [31:0] id_prog_reg;
  logic [31:0] clrev_prog_reg;
  logic [31:0] subid_prog_reg;
  logic [31:0] latgnt_prog_reg;
  logic cfg_done_reg;
  logic [7:0] proxy_fields_reg;
  proxy_state_e proxy_state_reg;
  mem_state_e mem_state_reg;
  logic [31:0] rdata_reg;
  logic rd_subst_reg;
  logic [31:0] rd_other_reg;
  logic [31:0] mem_addr_reg;
  logic mem_write_reg;
  logic [3:0] mem_burst_reg;
  logic accept_reg;
  logic flushed_reg;
  logic cmd_valid_reg;
  logic [3:0] cmd_reg;
  logic [31:0] cmd_addr_reg;
  logic start_reg;
  logic io_reg;
  logic [31:0] id_mir_reg;
  logic [31:0] clrev_mir_reg;
  logic [31:0] subid_mir_reg;
  logic [15:0] latgnt_mir_reg;
  logic ext_ok_reg;
  logic proxy_ready;
  logic proxy_kick;
  logic proxy_flush;
  logic is_subst;
  logic [4:0] wr_slice;

  subst_mem_if sm ();

  subst_mem u_subst_mem (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .mem(sm)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Picks the strongest command the permits allow for this burst
  function automatic logic [3:0] pick_cmd(input logic wr, input logic [3:0] len,
                                          input logic [31:0] pol);
    logic [3:0] c;
    c = wr ? pci_master_cfg_pkg::PCI_CMD_MEM_WRITE : pci_master_cfg_pkg::PCI_CMD_MEM_READ;
    if (wr) begin
      if (pol[pci_master_cfg_pkg::POL_WR_INV] && len >= pci_master_cfg_pkg::BURST_LINE_MIN) begin
        c = pci_master_cfg_pkg::PCI_CMD_WRITE_INV;
      end
    end else if (pol[pci_master_cfg_pkg::POL_RD_MULT]
                 && len >= pci_master_cfg_pkg::BURST_MULT_MIN) begin
      c = pci_master_cfg_pkg::PCI_CMD_READ_MULT;
    end else if (pol[pci_master_cfg_pkg::POL_RD_LINE]
                 && len >= pci_master_cfg_pkg::BURST_LINE_MIN) begin
      c = pci_master_cfg_pkg::PCI_CMD_READ_LINE;
    end
    return c;
  endfunction

  assign is_subst = reg_addr_i >= pci_master_cfg_pkg::OFF_SUBST_BASE
    && reg_addr_i < pci_master_cfg_pkg::OFF_SUBST_BASE + pci_master_cfg_pkg::SUBST_SPAN;
  assign wr_slice = reg_addr_i[6:2];
  assign proxy_ready = proxy_state_reg == PX_IDLE;
  assign proxy_kick = reg_wr_i && hit(reg_addr_i, pci_master_cfg_pkg::OFF_PROXY_CMD)
    && proxy_ready;
  // Flush decision per command type while mastering is off
  assign proxy_flush = !bus_mastering_allowed_i && (proxy_fields_reg[pci_master_cfg_pkg::PROXY_TYPE_BIT]
    ? policy_reg[pci_master_cfg_pkg::POL_IO_FLUSH]
    : policy_reg[pci_master_cfg_pkg::POL_CFG_FLUSH]);

  // Substitution memory ports; one write port serves the whole array
  assign sm.wr_en = reg_wr_i && is_subst;
  assign sm.wr_idx = wr_slice;
  assign sm.wr_data = reg_wdata_i[pci_master_cfg_pkg::SUBST_MSB:pci_master_cfg_pkg::SUBST_LSB];
  // The memory path re-reads its slice in the lookup cycle, so idle cycles may serve the bus
  assign sm.rd_idx = (mem_state_reg != MP_IDLE)
    ? mem_addr_reg[pci_master_cfg_pkg::SLICE_MSB:pci_master_cfg_pkg::SLICE_LSB]
    : (reg_rd_i && is_subst) ? wr_slice
    : mem_req_addr_i[pci_master_cfg_pkg::SLICE_MSB:pci_master_cfg_pkg::SLICE_LSB];

  // Register writes
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      policy_reg <= pci_master_cfg_pkg::POL_RESET;
      id_prog_reg <= pci_master_cfg_pkg::ID_PROG_RESET;
      clrev_prog_reg <= pci_master_cfg_pkg::CLREV_PROG_RESET;
      subid_prog_reg <= pci_master_cfg_pkg::SUBID_PROG_RESET;
      latgnt_prog_reg <= pci_master_cfg_pkg::LATGNT_RESET;
      cfg_done_reg <= 1'b0;
    end else if (reg_wr_i) begin
      if (hit(reg_addr_i, pci_master_cfg_pkg::OFF_MST_POLICY)) begin
        policy_reg <= reg_wdata_i & pci_master_cfg_pkg::POL_MASK;
      end
      if (hit(reg_addr_i, pci_master_cfg_pkg::OFF_ID_PROG)) begin
        id_prog_reg <= reg_wdata_i;
      end
      if (hit(reg_addr_i, pci_master_cfg_pkg::OFF_CLREV_PROG)) begin
        clrev_prog_reg <= reg_wdata_i;
      end
      if (hit(reg_addr_i, pci_master_cfg_pkg::OFF_SUBID_PROG)) begin
        subid_prog_reg <= reg_wdata_i;
      end
      if (hit(reg_addr_i, pci_master_cfg_pkg::OFF_LATGNT_PROG)) begin
        latgnt_prog_reg <= reg_wdata_i & pci_master_cfg_pkg::LATGNT_MASK;
      end
      if (hit(reg_addr_i, pci_master_cfg_pkg::OFF_CFG_DONE)) begin
        cfg_done_reg <= reg_wdata_i[0];
      end
    end
  end

  // Read data path; substitution reads use the memory's registered output
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_other_reg <= 32'h0000_0000;
      rd_subst_reg <= 1'b0;
    end else begin
      rd_subst_reg <= reg_rd_i && is_subst;
      rd_other_reg <= 32'h0000_0000;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          pci_master_cfg_pkg::OFF_MST_POLICY: rd_other_reg <= policy_reg;
          pci_master_cfg_pkg::OFF_ID_PROG: rd_other_reg <= id_prog_reg;
          pci_master_cfg_pkg::OFF_CLREV_PROG: rd_other_reg <= clrev_prog_reg;
          pci_master_cfg_pkg::OFF_SUBID_PROG: rd_other_reg <= subid_prog_reg;
          pci_master_cfg_pkg::OFF_LATGNT_PROG: rd_other_reg <= latgnt_prog_reg;
          pci_master_cfg_pkg::OFF_CFG_DONE: rd_other_reg <= {31'h0000_0000, cfg_done_reg};
          pci_master_cfg_pkg::OFF_PROXY_CMD: rd_other_reg <= {proxy_ready, 23'h00_0000,
                                                              proxy_fields_reg};
          default: rd_other_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Spare read data register; always held at zero, so it adds nothing to either read result
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Proxy command sequencer
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      proxy_state_reg <= PX_IDLE;
      proxy_fields_reg <= 8'h00;
      start_reg <= 1'b0;
      io_reg <= 1'b0;
    end else begin
      start_reg <= 1'b0;
      unique case (proxy_state_reg)
        PX_IDLE: begin
          if (proxy_kick) begin
            proxy_fields_reg <= reg_wdata_i[7:0] & pci_master_cfg_pkg::PROXY_WR_MASK[7:0];
            proxy_state_reg <= PX_ISSUE;
          end
        end
        PX_ISSUE: begin
          if (proxy_flush) begin
            proxy_state_reg <= PX_IDLE;
          end else if (bus_mastering_allowed_i) begin
            start_reg <= 1'b1;
            io_reg <= proxy_fields_reg[pci_master_cfg_pkg::PROXY_TYPE_BIT];
            proxy_state_reg <= PX_WAIT;
          end
        end
        PX_WAIT: begin
          if (proxy_done_i) begin
            proxy_state_reg <= PX_IDLE;
          end
        end
      endcase
    end
  end

  // Internal master memory port: lookup, translate, pick command
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_state_reg <= MP_IDLE;
      mem_addr_reg <= 32'h0000_0000;
      mem_write_reg <= 1'b0;
      mem_burst_reg <= 4'h0;
      accept_reg <= 1'b0;
      flushed_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      cmd_reg <= 4'h0;
      cmd_addr_reg <= 32'h0000_0000;
    end else begin
      accept_reg <= 1'b0;
      flushed_reg <= 1'b0;
      cmd_valid_reg <= 1'b0;
      unique case (mem_state_reg)
        MP_IDLE: begin
          if (mem_req_valid_i) begin
            if (!bus_mastering_allowed_i
                && policy_reg[pci_master_cfg_pkg::POL_MEM_FLUSH]) begin
              accept_reg <= 1'b1;
              flushed_reg <= 1'b1;
            end else if (bus_mastering_allowed_i) begin
              accept_reg <= 1'b1;
              mem_addr_reg <= mem_req_addr_i;
              mem_write_reg <= mem_req_write_i;
              mem_burst_reg <= mem_req_burst_i;
              mem_state_reg <= MP_LOOKUP;
            end
          end
        end
        MP_LOOKUP: begin
          mem_state_reg <= MP_EMIT;
        end
        MP_EMIT: begin
          cmd_valid_reg <= 1'b1;
          cmd_reg <= pick_cmd(mem_write_reg, mem_burst_reg, policy_reg);
          cmd_addr_reg <= {sm.rd_data, mem_addr_reg[22:0]};
          mem_state_reg <= MP_IDLE;
        end
      endcase
    end
  end

  // Live configuration copies taken on PCI reset
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      id_mir_reg <= pci_master_cfg_pkg::ID_PROG_RESET;
      clrev_mir_reg <= pci_master_cfg_pkg::CLREV_PROG_RESET;
      subid_mir_reg <= pci_master_cfg_pkg::SUBID_PROG_RESET;
      latgnt_mir_reg <= 16'h0000;
    end else if (pci_reset_i) begin
      id_mir_reg <= id_prog_reg;
      clrev_mir_reg <= clrev_prog_reg;
      subid_mir_reg <= subid_prog_reg;
      latgnt_mir_reg <= latgnt_prog_reg[15:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_ok_reg <= 1'b0;
    end else begin
      ext_ok_reg <= cfg_done_reg;
    end
  end

  // Substitution reads: memory data arrive a cycle after the strobe, so the
  // read port is lent to the bus while the memory path is idle
  assign reg_rdata_o = rd_subst_reg
    ? {sm.rd_data, 23'h00_0000} | rdata_reg
    : rd_other_reg | rdata_reg;
  assign mem_req_accept_o = accept_reg;
  assign mem_req_flushed_o = flushed_reg;
  assign mem_cmd_valid_o = cmd_valid_reg;
  assign mem_cmd_o = cmd_reg;
  assign mem_cmd_addr_o = cmd_addr_reg;
  assign proxy_start_o = start_reg;
  assign proxy_io_o = io_reg;
  assign identity_mirror_o = id_mir_reg;
  assign class_rev_mirror_o = clrev_mir_reg;
  assign subsystem_mirror_o = subid_mir_reg;
  assign latency_grant_mirror_o = latgnt_mir_reg;
  assign ext_access_allowed_o = ext_ok_reg;
endmodule // pci_master_cfg_and_hook_regs

/* File: testbench/pci_bus_engine_model.sv */
// Bus engine stand-in that runs proxy cycles and counts them
`timescale 1ns/1ps
module pci_bus_engine_model (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] delay_i,
  input wire logic proxy_start_i,
  output logic proxy_done_o,
  output logic [7:0] starts_o
);
  logic busy_reg;
  logic [3:0] cnt_reg;
  // Delay input lets the bench answer promptly or slowly
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      proxy_done_o <= 1'b0;
      starts_o <= 8'h00;
    end else begin
      proxy_done_o <= 1'b0;
      if (proxy_start_i) begin
        busy_reg <= 1'b1;
        cnt_reg <= delay_i;
        starts_o <= starts_o + 8'h01;
      end else if (busy_reg && cnt_reg == 4'h0) begin
        busy_reg <= 1'b0;
        proxy_done_o <= 1'b1;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule // pci_bus_engine_model

/* File: testbench/pci_master_cfg_monitor.sv */
// Port checks for the master policy, substitution and hook register block
`timescale 1ns/1ps
module pci_master_cfg_monitor (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic bus_mastering_allowed_i,
  input wire logic pci_reset_i,
  input wire logic [31:0] mem_req_addr_i,
  input wire logic mem_req_accept_o,
  input wire logic mem_req_flushed_o,
  input wire logic mem_cmd_valid_o,
  input wire logic [3:0] mem_cmd_o,
  input wire logic [31:0] mem_cmd_addr_o,
  input wire logic [31:0] identity_mirror_o,
  input wire logic ext_access_allowed_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [31:0] pol_reg;
  logic [31:0] id_reg;
  logic done_reg;
  // Shadows follow software writes; policy must not change mid-request
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pol_reg <= pci_master_cfg_pkg::POL_RESET;
    end else if (reg_wr_i && reg_addr_i == 12'h390) begin
      pol_reg <= reg_wdata_i & pci_master_cfg_pkg::POL_MASK;
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      id_reg <= pci_master_cfg_pkg::ID_PROG_RESET;
    end else if (reg_wr_i && reg_addr_i == 12'h394) begin
      id_reg <= reg_wdata_i;
    end
  end
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      done_reg <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == 12'h3AC) begin
      done_reg <= reg_wdata_i[0];
    end
  end
  AST_CMD_SET: assert property (mem_cmd_valid_o |-> mem_cmd_o inside {4'h6, 4'h7, 4'hC, 4'hE, 4'hF})
    else $error("unexpected memory command");
  AST_RD_MULT: assert property (mem_cmd_valid_o && mem_cmd_o == 4'hC |-> pol_reg[2])
    else $error("read multiple without permit");
  AST_RD_LINE: assert property (mem_cmd_valid_o && mem_cmd_o == 4'hE |-> pol_reg[1])
    else $error("read line without permit");
  AST_WR_INV: assert property (mem_cmd_valid_o && mem_cmd_o == 4'hF |-> pol_reg[0])
    else $error("write invalidate without permit");
  AST_CMD_LAT: assert property (mem_req_accept_o && !mem_req_flushed_o |-> ##2 mem_cmd_valid_o)
    else $error("kept request gave no command");
  AST_FLUSH_QUIET: assert property (mem_req_flushed_o |-> !mem_cmd_valid_o [*3])
    else $error("flushed request reached the bus");
  AST_FLUSH_WHEN: assert property (mem_req_flushed_o |-> mem_req_accept_o && !$past(bus_mastering_allowed_i))
    else $error("flush while mastering allowed");
  AST_XLATE: assert property (mem_req_accept_o && !mem_req_flushed_o |->
      ##2 mem_cmd_addr_o[22:0] == $past(mem_req_addr_i[22:0], 3))
    else $error("low address bits altered");
  AST_SUBST_LOW: assert property (reg_rd_i && reg_addr_i[11:7] == 5'h06 |=> reg_rdata_o[22:0] == 23'h0)
    else $error("substitution low bits not zero");
  AST_MIRROR: assert property (pci_reset_i |=> identity_mirror_o == $past(id_reg))
    else $error("identity mirror not loaded");
  AST_EXT: assert property (ext_access_allowed_o == $past(done_reg))
    else $error("external access does not follow flag");
endmodule // pci_master_cfg_monitor
bind pci_master_cfg_and_hook_regs pci_master_cfg_monitor pci_master_cfg_monitor_inst (.*);

/* File: testbench/tb_pci_master_cfg_and_hook_regs.sv */
// Testbench for the master policy, substitution and hook register block
`timescale 1ns/1ps
module tb_pci_master_cfg_and_hook_regs;
  logic clk, rst, wr, rd, mst, prst, mv, mw, done, acc, fl, cv, pst, pio, ext;
  logic [11:0] addr;
  logic [31:0] wd, rdat, maddr, caddr, idm, clm, sbm, q;
  logic [3:0] mb, cmd, dly;
  logic [15:0] lgm;
  logic [7:0] starts, s;
  int i;
  int num_errors = 0;
  int num_checks = 0;
  pci_master_cfg_and_hook_regs pci_master_cfg_and_hook_regs_inst (.core_clk_i(clk),
    .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .bus_mastering_allowed_i(mst), .pci_reset_i(prst),
    .mem_req_valid_i(mv), .mem_req_write_i(mw), .mem_req_burst_i(mb), .mem_req_addr_i(maddr),
    .mem_req_accept_o(acc), .mem_req_flushed_o(fl), .mem_cmd_valid_o(cv), .mem_cmd_o(cmd),
    .mem_cmd_addr_o(caddr), .proxy_done_i(done), .proxy_start_o(pst), .proxy_io_o(pio),
    .identity_mirror_o(idm), .class_rev_mirror_o(clm), .subsystem_mirror_o(sbm),
    .latency_grant_mirror_o(lgm), .ext_access_allowed_o(ext));
  pci_bus_engine_model pci_bus_engine_model_inst (.core_clk_i(clk), .sys_rst_i(rst),
    .delay_i(dly), .proxy_start_i(pst), .proxy_done_o(done), .starts_o(starts));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 40) begin
      num_errors++;
      results();
    end
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(input logic [11:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    q = rdat;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rreg(a);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic rdy(input logic e, input logic [7:0] f);
    repeat (3) @(posedge clk);
    rchk(12'h398, {e, 23'h0, f});
  endtask
  // Outputs are looked at on the falling edge, away from the edge that launches them
  task automatic wacc();
    int k;
    for (k = 0; k < 40 && acc !== 1'b1; k++) @(negedge clk);
    guard(k);
  endtask
  task automatic mreq(input logic w, input logic [3:0] b, input logic [3:0] ec);
    int k;
    @(posedge clk);
    mv <= 1'b1;
    mw <= w;
    mb <= b;
    wacc();
    @(posedge clk);
    mv <= 1'b0;
    for (k = 0; k < 40 && cv !== 1'b1; k++) @(negedge clk);
    guard(k);
    chk("command", {28'h0, ec}, {28'h0, cmd});
    chk("address", 32'hAB92_3456, caddr);
  endtask
  task automatic quiet(input string n, ref logic g);
    repeat (4) begin
      @(negedge clk);
      chk(n, 32'h0, {31'h0, g});
    end
  endtask
  initial begin
    rst = 1'b1;
    {wr, rd, prst, mv, mw} = 5'h00;
    mst = 1'b1;
    addr = 12'h000;
    wd = 32'h0;
    mb = 4'h0;
    dly = 4'h6;
    maddr = 32'h0B12_3456;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rchk(12'h390, 32'h7);
    rchk(12'h394, pci_master_cfg_pkg::ID_PROG_RESET);
    rchk(12'h39C, 32'h1180_0001);
    rchk(12'h3AC, 32'h0);
    rchk(12'h010, 32'h0);
    rchk(12'h37C, 32'h0);
    wreg(12'h37C, 32'hFFFF_FFFF);
    rchk(12'h37C, 32'hFF80_0000);
    wreg(12'h390, 32'hFFFF_FFFF);
    rchk(12'h390, 32'h707);
    wreg(12'h3A4, 32'hFFFF_FFFF);
    rchk(12'h3A4, 32'hFFFF);
    wreg(12'h3AC, 32'hFFFF_FFFF);
    rchk(12'h3AC, 32'h1);
    chk("access", 32'h1, {31'h0, ext});
    $display("test registers done");
    wreg(12'h394, 32'hA5A5_5A5A);
    rchk(12'h394, 32'hA5A5_5A5A);
    wreg(12'h3A0, 32'h1234_5678);
    chk("id mirror", pci_master_cfg_pkg::ID_PROG_RESET, idm);
    @(posedge clk);
    prst <= 1'b1;
    @(posedge clk);
    prst <= 1'b0;
    @(negedge clk);
    chk("id mirror", 32'hA5A5_5A5A, idm);
    chk("class mirror", 32'h1180_0001, clm);
    chk("sub mirror", 32'h1234_5678, sbm);
    chk("lat mirror", 32'hFFFF, {16'h0, lgm});
    $display("test hooks done");
    wreg(12'h358, 32'hAB80_0000);
    mreq(1'b0, 4'hB, 4'hE);
    mreq(1'b0, 4'hC, 4'hC);
    mreq(1'b0, 4'h7, 4'h6);
    mreq(1'b1, 4'h8, 4'hF);
    mreq(1'b1, 4'h7, 4'h7);
    wreg(12'h390, 32'h0);
    mreq(1'b0, 4'hC, 4'h6);
    mreq(1'b0, 4'h8, 4'h6);
    mreq(1'b1, 4'h8, 4'h7);
    $display("test commands done");
    @(posedge clk);
    mst <= 1'b0;
    mv <= 1'b1;
    quiet("held off", acc);
    wreg(12'h390, 32'h100);
    wacc();
    chk("flushed", 32'h1, {31'h0, fl});
    @(posedge clk);
    mv <= 1'b0;
    quiet("no command", cv);
    $display("test memory flush done");
    s = starts;
    wreg(12'h390, 32'h400);
    wreg(12'h398, 32'h1);
    rdy(1'b1, 8'h01);
    wreg(12'h390, 32'h200);
    wreg(12'h398, 32'h5);
    rdy(1'b1, 8'h05);
    chk("bus cycles", {24'h0, s}, {24'h0, starts});
    wreg(12'h390, 32'h0);
    wreg(12'h398, 32'h5);
    rdy(1'b0, 8'h05);
    @(posedge clk);
    mst <= 1'b1;
    for (i = 0; i < 40 && q[31] !== 1'b1; i++) rreg(12'h398);
    guard(i);
    chk("proxy ready", 32'h8000_0005, q);
    chk("proxy io", 32'h1, {31'h0, pio});
    chk("bus cycles", {24'h0, s + 8'h1}, {24'h0, starts});
    dly <= 4'h0;
    wreg(12'h398, 32'h1);
    rdy(1'b1, 8'h01);
    chk("proxy io", 32'h0, {31'h0, pio});
    chk("bus cycles", {24'h0, s + 8'h2}, {24'h0, starts});
    $display("test proxy done");
    results();
  end
endmodule // tb_pci_master_cfg_and_hook_regs
